// ### hw/tmc_timer.sv
// Sixteen-bit timer/counter with AXI4-Lite register access
// Operation
// - Control bit 7 selects buffered 16-bit access or two plain byte accesses.
// - Control bit 6 is read-only: 1 when system clock comes from this oscillator.
// - Two-bit prescale field: 11 is 1:8, 10 is 1:4, 01 is 1:2, 00 is 1:1.
// - Oscillator runs while its enable bit is 1, shut off while 0.
// - External source synchronised when sync bit is 0, raw when 1; ignored internally.
// - Source bit 0 counts instruction clock; 1 counts external or oscillator rising edges.
// - Counter advances only while the run bit is 1.
// - Modes timer, synchronous counter, asynchronous counter follow source and sync bits.
// - While the run bit is 1 both clock pins are inputs and read back as 0.
// - Buffered mode: low byte read copies live high byte into the high buffer.
// - Buffered mode: low byte write loads high buffer into live high byte together.
// - Buffered mode: live high byte reachable only through the buffer.
// - Low byte writes clear the prescaler; high byte writes leave it alone.
// - Enabled oscillator keeps running through every power-managed mode.
// - Count wraps FFFF to 0000 and sets overflow flag; enable gates the interrupt.
// - Special event trigger resets count in timer or synchronous counter mode.
// - A count write in the same cycle as the trigger wins over it.
//
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
module tmc_timer
   import tmc_pkg::*;
#(
   parameter int INSTR_DIV = TMC_INSTR_DIV
) (
   input  wire  logic        CLK,
   input  wire  logic        RST,
   input  wire  logic [3:0]  S_AXI_AWADDR,
   input  wire  logic        S_AXI_AWVALID,
   output logic              S_AXI_AWREADY,
   input  wire  logic [31:0] S_AXI_WDATA,
   input  wire  logic [3:0]  S_AXI_WSTRB,
   input  wire  logic        S_AXI_WVALID,
   output logic              S_AXI_WREADY,
   output logic [1:0]        S_AXI_BRESP,
   output logic              S_AXI_BVALID,
   input  wire  logic        S_AXI_BREADY,
   input  wire  logic [3:0]  S_AXI_ARADDR,
   input  wire  logic        S_AXI_ARVALID,
   output logic              S_AXI_ARREADY,
   output logic [31:0]       S_AXI_RDATA,
   output logic [1:0]        S_AXI_RRESP,
   output logic              S_AXI_RVALID,
   input  wire  logic        S_AXI_RREADY,
   input  wire  logic        EXT_CLOCK_PIN,
   input  wire  logic        OSC_INPUT_PIN,
   input  wire  logic        SYSCLK_FROM_OSC,
   input  wire  logic        SPECIAL_EVENT_TRIGGER,
   input  wire  logic [1:0]  PIN_DIRECTION_BITS,
   input  wire  logic [1:0]  PIN_LEVEL,
   output logic [1:0]        PIN_OE_N,
   output logic [1:0]        PORT_READ_VALUE,
   output logic              OSC_ENABLE,
   output logic              OVERFLOW_FLAG,
   output logic              OVERFLOW_IRQ
);

   localparam int DIV_W = (INSTR_DIV > 1) ? $clog2(INSTR_DIV) : 1;
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(INSTR_DIV - 1);

   // Prescale ratio as a mask of the prescaler bits that must all be set
   function automatic logic [2:0] presc_mask(input logic [1:0] sel);
      case (sel)
         2'b11:   presc_mask = 3'h7;
         2'b10:   presc_mask = 3'h3;
         2'b01:   presc_mask = 3'h1;
         default: presc_mask = 3'h0;
      endcase
   endfunction : presc_mask

   tmc_ctl_s    ctl;
   logic [15:0] count;
   logic [7:0]  high_buf;
   logic [2:0]  presc;
   logic [DIV_W-1:0] div_cnt;
   logic        instr_tick;
   logic        ext_meta;
   logic        ext_sync;
   logic        ext_sync_d;
   logic        ext_raw_d;
   logic        ovf_flag;
   logic        ovf_ie;

   logic        aw_held;
   logic [3:0]  aw_addr;
   logic        w_held;
   logic [7:0]  w_data;
   logic        w_lane0;
   logic        do_write;
   logic        do_read;

   logic        wr_ctl;
   logic        wr_low;
   logic        wr_high;
   logic        wr_stat;
   logic        rd_low;
   logic        ext_level;
   logic        ext_edge;
   logic        src_tick;
   logic        presc_term;
   logic        inc;
   logic        trig_reset;
   logic        ovf_set;
   tmc_mode_e   mode;
   logic [7:0]  next_rdata;
   logic        next_rvalid_ok;

   // Bus transfers ----------------------------------------------------------

   assign do_write = aw_held && w_held && !S_AXI_BVALID;
   assign do_read  = S_AXI_ARREADY && S_AXI_ARVALID;

   // Strobe lane 0 must be set for the 8-bit register to change
   assign wr_ctl  = do_write && w_lane0 && (aw_addr == TMC_ADDR_CONTROL);
   assign wr_low  = do_write && w_lane0 && (aw_addr == TMC_ADDR_LOW);
   assign wr_high = do_write && w_lane0 && (aw_addr == TMC_ADDR_HIGH);
   assign wr_stat = do_write && w_lane0 && (aw_addr == TMC_ADDR_STATUS);
   assign rd_low  = do_read && (S_AXI_ARADDR == TMC_ADDR_LOW);

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         S_AXI_AWREADY <= 1'b0;
         aw_held       <= 1'b0;
         aw_addr       <= 4'h0;
      end else begin
         if (S_AXI_AWREADY && S_AXI_AWVALID) begin
            S_AXI_AWREADY <= 1'b0;
            aw_held       <= 1'b1;
            aw_addr       <= S_AXI_AWADDR;
         end else if (!aw_held && !S_AXI_BVALID) begin
            S_AXI_AWREADY <= 1'b1;
         end
         if (do_write) begin
            aw_held <= 1'b0;
         end
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         S_AXI_WREADY <= 1'b0;
         w_held       <= 1'b0;
         w_data       <= 8'h00;
         w_lane0      <= 1'b0;
      end else begin
         if (S_AXI_WREADY && S_AXI_WVALID) begin
            S_AXI_WREADY <= 1'b0;
            w_held       <= 1'b1;
            w_data       <= S_AXI_WDATA[7:0];
            w_lane0      <= S_AXI_WSTRB[0];
         end else if (!w_held && !S_AXI_BVALID) begin
            S_AXI_WREADY <= 1'b1;
         end
         if (do_write) begin
            w_held <= 1'b0;
         end
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP  <= TMC_RESP_OKAY;
      end else if (do_write) begin
         S_AXI_BVALID <= 1'b1;
         S_AXI_BRESP  <= (aw_addr[1:0] == 2'b00) ? TMC_RESP_OKAY : TMC_RESP_SLVERR;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
         S_AXI_BVALID <= 1'b0;
      end
   end

   // Read mux; high address shows the buffer in wide mode
   always_comb begin
      next_rdata     = 8'h00;
      next_rvalid_ok = 1'b1;
      case (S_AXI_ARADDR)
         TMC_ADDR_CONTROL: next_rdata = ctl;
         TMC_ADDR_LOW:     next_rdata = count[7:0];
         TMC_ADDR_HIGH:    next_rdata = ctl.wide_access_enable ? high_buf
                                                               : count[15:8];
         TMC_ADDR_STATUS: begin
            next_rdata[TMC_STAT_FLAG_BIT] = ovf_flag;
            next_rdata[TMC_STAT_IE_BIT]   = ovf_ie;
         end
         default:          next_rvalid_ok = 1'b0;
      endcase
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID  <= 1'b0;
         S_AXI_RDATA   <= 32'h0000_0000;
         S_AXI_RRESP   <= TMC_RESP_OKAY;
      end else begin
         if (do_read) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b1;
            S_AXI_RDATA   <= {24'h00_0000, next_rdata};
            S_AXI_RRESP   <= next_rvalid_ok ? TMC_RESP_OKAY : TMC_RESP_SLVERR;
         end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
         end else if (!S_AXI_RVALID) begin
            S_AXI_ARREADY <= 1'b1;
         end
      end
   end

   // Control register -------------------------------------------------------

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         ctl <= TMC_CTL_RESET;
      end else begin
         if (wr_ctl) begin
            ctl <= tmc_ctl_s'((w_data & TMC_CTL_WMASK) | (ctl & ~TMC_CTL_WMASK));
         end
         // Status bit tracks the system clock mux, never software
         ctl.sysclk_from_osc_status <= SYSCLK_FROM_OSC;
      end
   end

   // Oscillator enable is a plain register bit, so power-managed modes that
   // gate the core do not touch it and the oscillator keeps running
   assign OSC_ENABLE = ctl.osc_enable;

   // Clock sources ----------------------------------------------------------

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         div_cnt <= '0;
      end else if (div_cnt == DIV_LAST) begin
         div_cnt <= '0;
      end else begin
         div_cnt <= div_cnt + DIV_W'(1);
      end
   end

   assign instr_tick = (div_cnt == DIV_LAST);

   // Oscillator replaces the external pin when it is enabled
   assign ext_level = ctl.osc_enable ? OSC_INPUT_PIN : EXT_CLOCK_PIN;

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         ext_meta   <= 1'b0;
         ext_sync   <= 1'b0;
         ext_sync_d <= 1'b0;
         ext_raw_d  <= 1'b0;
      end else begin
         ext_meta   <= ext_level;
         ext_sync   <= ext_meta;
         ext_sync_d <= ext_sync;
         ext_raw_d  <= ext_level;
      end
   end

   // Unsynchronised path sees the edge two cycles sooner but takes the pin
   // as is; the synchronised path pays latency for a clean edge
   assign ext_edge = ctl.ext_sync_disable ? (ext_level && !ext_raw_d)
                                          : (ext_sync && !ext_sync_d);

   assign src_tick = ctl.clock_source_select ? ext_edge : instr_tick;

   always_comb begin
      if (!ctl.clock_source_select) begin
         mode = TMC_MODE_TIMER;
      end else if (!ctl.ext_sync_disable) begin
         mode = TMC_MODE_SYNC_COUNT;
      end else begin
         mode = TMC_MODE_ASYNC_CNT;
      end
   end

   // Prescaler and count ----------------------------------------------------

   assign presc_term = ((presc & presc_mask(ctl.prescale_select))
                        == presc_mask(ctl.prescale_select));
   assign inc        = ctl.run_control && src_tick && presc_term;
   assign trig_reset = SPECIAL_EVENT_TRIGGER && (mode != TMC_MODE_ASYNC_CNT);
   assign ovf_set    = inc && !wr_low && !(wr_high && !ctl.wide_access_enable)
                       && !trig_reset && (count == TMC_COUNT_MAX);

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         presc <= TMC_PRESC_RESET;
      end else if (wr_low) begin
         presc <= TMC_PRESC_RESET;
      end else if (ctl.run_control && src_tick) begin
         presc <= presc_term ? TMC_PRESC_RESET : presc + 3'h1;
      end
   end

   // Writes beat the trigger, which beats counting
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         count <= TMC_COUNT_RESET;
      end else if (wr_low) begin
         count[7:0] <= w_data;
         if (ctl.wide_access_enable) begin
            count[15:8] <= high_buf;
         end
      end else if (wr_high && !ctl.wide_access_enable) begin
         count[15:8] <= w_data;
      end else if (trig_reset) begin
         count <= TMC_COUNT_RESET;
      end else if (inc) begin
         count <= count + 16'h0001;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         high_buf <= TMC_BYTE_RESET;
      end else if (wr_high && ctl.wide_access_enable) begin
         high_buf <= w_data;
      end else if (rd_low && ctl.wide_access_enable) begin
         high_buf <= count[15:8];
      end
   end

   // Overflow flag: set wins over a clear in the same cycle
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         ovf_flag <= 1'b0;
         ovf_ie   <= 1'b0;
      end else begin
         if (ovf_set) begin
            ovf_flag <= 1'b1;
         end else if (wr_stat && w_data[TMC_STAT_FLAG_BIT]) begin
            ovf_flag <= 1'b0;
         end
         if (wr_stat) begin
            ovf_ie <= w_data[TMC_STAT_IE_BIT];
         end
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         OVERFLOW_FLAG <= 1'b0;
         OVERFLOW_IRQ  <= 1'b0;
      end else begin
         OVERFLOW_FLAG <= ovf_flag;
         OVERFLOW_IRQ  <= ovf_flag && ovf_ie;
      end
   end

   // Pin control ------------------------------------------------------------

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         PIN_OE_N        <= 2'b11;
         PORT_READ_VALUE <= 2'b00;
      end else if (ctl.run_control) begin
         PIN_OE_N        <= 2'b11;
         PORT_READ_VALUE <= 2'b00;
      end else begin
         PIN_OE_N        <= PIN_DIRECTION_BITS;
         PORT_READ_VALUE <= PIN_LEVEL;
      end
   end

endmodule : tmc_timer

// ### hw/tmc_pkg.sv
// Shared constants and types for the sixteen-bit timer/counter
package tmc_pkg;

   // Register byte addresses on the AXI4-Lite slave
   localparam logic [3:0] TMC_ADDR_CONTROL = 4'h0;
   localparam logic [3:0] TMC_ADDR_LOW     = 4'h4;
   localparam logic [3:0] TMC_ADDR_HIGH    = 4'h8;
   localparam logic [3:0] TMC_ADDR_STATUS  = 4'hc;

   // Field positions in the status register
   localparam int TMC_STAT_FLAG_BIT = 0;
   localparam int TMC_STAT_IE_BIT   = 1;

   // Control register layout, bit 7 down to bit 0
   typedef struct packed {
      logic       wide_access_enable;
      logic       sysclk_from_osc_status;
      logic [1:0] prescale_select;
      logic       osc_enable;
      logic       ext_sync_disable;
      logic       clock_source_select;
      logic       run_control;
   } tmc_ctl_s;

   localparam tmc_ctl_s TMC_CTL_RESET = '{default: 1'b0};

   // Mask of writable control bits; the clock status bit is read-only
   localparam logic [7:0] TMC_CTL_WMASK = 8'hbf;

   // Operating modes derived from the source and sync bits
   typedef enum logic [1:0] {
      TMC_MODE_TIMER      = 2'b00,
      TMC_MODE_SYNC_COUNT = 2'b01,
      TMC_MODE_ASYNC_CNT  = 2'b10
   } tmc_mode_e;

   // Instruction clock is the core clock divided by four
   localparam int TMC_INSTR_DIV = 4;

   localparam logic [15:0] TMC_COUNT_RESET = 16'h0000;
   localparam logic [15:0] TMC_COUNT_MAX   = 16'hffff;
   localparam logic [7:0]  TMC_BYTE_RESET  = 8'h00;
   localparam logic [2:0]  TMC_PRESC_RESET = 3'h0;

   localparam logic [1:0] TMC_RESP_OKAY   = 2'b00;
   localparam logic [1:0] TMC_RESP_SLVERR = 2'b10;

endpackage : tmc_pkg

// ### tb/tmc_clk_source.sv
// Far-side clock sources: external clock pin and low-power crystal
module tmc_clk_source #(
   parameter int HALF  = 5,
   parameter int START = 24
) (
   input  wire logic CLK,
   input  wire logic ext_run,
   input  wire logic osc_en,
   output logic      ext_pin,
   output logic      osc_pin
);
   timeunit 1ns;
   timeprecision 100ps;
   int ext_cnt = 0;
   int osc_cnt = 0;
   // Pin rests low between bursts instead of holding its last level
   always @(posedge CLK) begin
      ext_cnt <= ext_run ? ext_cnt + 1 : 0;
      if (!ext_run) ext_pin <= 1'b0;
      else if ((ext_cnt + 1) % HALF == 0) ext_pin <= ~ext_pin;
   end
   // Silent until the crystal has started; no power-mode input can stop it
   always @(posedge CLK) begin
      osc_cnt <= osc_en ? osc_cnt + 1 : 0;
      if (!osc_en) osc_pin <= 1'b0;
      else if (osc_cnt >= START && osc_cnt % HALF == 0) osc_pin <= ~osc_pin;
   end
endmodule : tmc_clk_source

// ### tb/tmc_timer_monitor.sv
// Port checker for the timer/counter bus, pins and overflow outputs
module tmc_timer_monitor (
   input logic        CLK,
   input logic        RST,
   input logic        S_AXI_AWVALID,
   input logic        S_AXI_AWREADY,
   input logic        S_AXI_WVALID,
   input logic        S_AXI_WREADY,
   input logic [1:0]  S_AXI_BRESP,
   input logic        S_AXI_BVALID,
   input logic        S_AXI_BREADY,
   input logic        S_AXI_ARVALID,
   input logic        S_AXI_ARREADY,
   input logic [31:0] S_AXI_RDATA,
   input logic        S_AXI_RVALID,
   input logic        S_AXI_RREADY,
   input logic [1:0]  PIN_DIRECTION_BITS,
   input logic [1:0]  PIN_LEVEL,
   input logic [1:0]  PIN_OE_N,
   input logic [1:0]  PORT_READ_VALUE,
   input logic        OSC_ENABLE,
   input logic        OVERFLOW_FLAG,
   input logic        OVERFLOW_IRQ
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   sequence wr_taken;
      S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
   endsequence
   sequence wr_answer;
      !S_AXI_AWREADY ##1 S_AXI_BVALID;
   endsequence
   write_answer_a: assert property (wr_taken |=> wr_answer)
      else $error("write answer late");
   bresp_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY
      |=> S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write answer dropped");
   read_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY
      |=> S_AXI_RVALID && !S_AXI_ARREADY) else $error("read answer late");
   rdata_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY
      |=> S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read answer dropped");
   ar_blocked_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
      else $error("read accepted while answering");
   pins_free_a: assert property (PIN_OE_N != 2'b11 |->
      PIN_OE_N == $past(PIN_DIRECTION_BITS) && PORT_READ_VALUE == $past(PIN_LEVEL))
      else $error("pin state wrong");
   irq_flag_a: assert property (OVERFLOW_IRQ |-> OVERFLOW_FLAG)
      else $error("interrupt without flag");
   flag_clear_a: assert property ($fell(OVERFLOW_FLAG) |-> $past(S_AXI_BVALID))
      else $error("flag cleared without write");
   osc_follow_a: assert property ($changed(OSC_ENABLE) |-> $rose(S_AXI_BVALID))
      else $error("oscillator enable moved alone");
endmodule : tmc_timer_monitor

bind tmc_timer tmc_timer_monitor u_mon (
   .CLK(CLK), .RST(RST), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
   .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
   .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
   .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
   .S_AXI_RREADY(S_AXI_RREADY), .PIN_DIRECTION_BITS(PIN_DIRECTION_BITS),
   .PIN_LEVEL(PIN_LEVEL), .PIN_OE_N(PIN_OE_N), .PORT_READ_VALUE(PORT_READ_VALUE),
   .OSC_ENABLE(OSC_ENABLE), .OVERFLOW_FLAG(OVERFLOW_FLAG), .OVERFLOW_IRQ(OVERFLOW_IRQ));

// ### tb/sixteen_bit_timer_counter_bench.sv
// Self-checking bench for the sixteen-bit timer/counter
module sixteen_bit_timer_counter_bench
   import tmc_pkg::*;
();
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct packed {logic [3:0] a; logic [7:0] d; logic [7:0] q; logic [1:0] r;} tmc_row_s;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
   logic [7:0]  wd = 8'h0, c;
   logic        awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
   logic        ext_run = 1'b0, sysclk = 1'b0, trig = 1'b0;
   logic [1:0]  pdir = 2'h0, plev = 2'h0, bresp, rresp, oe_n, prv, resp;
   logic        awr, wr_rdy, bvalid, arr, rvalid, osc_en, ovf, irq, ext_pin, osc_pin;
   logic [31:0] rdata, got, e;
   int          error_cnt = 0, compares = 0, n;
   tmc_row_s    rows [6] = '{
      '{TMC_ADDR_CONTROL, 8'hff, 8'hbf, TMC_RESP_OKAY}, '{TMC_ADDR_CONTROL, 8'h30, 8'h30, 2'b00},
      '{TMC_ADDR_STATUS, 8'h02, 8'h02, 2'b00}, '{4'h2, 8'h55, 8'h00, TMC_RESP_SLVERR},
      '{TMC_ADDR_LOW, 8'h5a, 8'h5a, 2'b00}, '{TMC_ADDR_HIGH, 8'ha5, 8'ha5, 2'b00}};
   always #2 clk = ~clk;
   tmc_timer DUT (
      .CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
      .S_AXI_WDATA({24'h0, wd}), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_rdy),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
      .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
      .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .EXT_CLOCK_PIN(ext_pin),
      .OSC_INPUT_PIN(osc_pin), .SYSCLK_FROM_OSC(sysclk), .SPECIAL_EVENT_TRIGGER(trig),
      .PIN_DIRECTION_BITS(pdir), .PIN_LEVEL(plev), .PIN_OE_N(oe_n), .PORT_READ_VALUE(prv),
      .OSC_ENABLE(osc_en), .OVERFLOW_FLAG(ovf), .OVERFLOW_IRQ(irq));
   tmc_clk_source far (.CLK(clk), .ext_run(ext_run), .osc_en(osc_en), .ext_pin(ext_pin),
      .osc_pin(osc_pin));
   task automatic complete_run;
      $display("mismatches %0d of %0d compares", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : complete_run
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      bit ad = 1'b0;
      bit dd = 1'b0;
      @(posedge clk);
      awaddr <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bready <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
         ad |= awr;
         dd |= wr_rdy;
         if (ad) awv <= 1'b0;
         if (dd) wv <= 1'b0;
      end while (!(ad && dd) && n < 100);
      while (bvalid !== 1'b1 && n < 200) begin
         @(posedge clk);
         n++;
      end
      resp = bresp;
      bready <= 1'b0;
      // A hung bus ends the run here rather than stalling every later step
      if (n >= 200) begin
         error_cnt++;
         complete_run();
      end
   endtask : wr
   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      araddr <= a;
      arv <= 1'b1;
      rready <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (arr !== 1'b1 && n < 100);
      arv <= 1'b0;
      do begin
         @(posedge clk);
         n++;
      end while (rvalid !== 1'b1 && n < 200);
      got = rdata;
      resp = rresp;
      rready <= 1'b0;
      if (n >= 200) begin
         error_cnt++;
         complete_run();
      end
   endtask : rd
   task automatic rng(input int lo, input int hi);
      rd(TMC_ADDR_LOW);
      chk({31'h0, got[7:0] >= lo && got[7:0] <= hi}, 32'h1);
   endtask : rng
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      rd(TMC_ADDR_CONTROL);
      chk(got, 32'h0);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         chk({30'h0, resp}, {30'h0, rows[i].r});
         rd(rows[i].a);
         chk({30'h0, resp}, {30'h0, rows[i].r});
         chk(got, {24'h0, rows[i].q});
      end
      pdir <= 2'b01;
      plev <= 2'b10;
      repeat (3) @(posedge clk);
      chk({28'h0, oe_n, prv}, 32'h6);
      wr(TMC_ADDR_CONTROL, 8'h01);
      repeat (2) @(posedge clk);
      chk({28'h0, oe_n, prv}, 32'hc);
      wr(TMC_ADDR_CONTROL, 8'h00);
      for (int p = 0; p < 4; p++) begin
         wr(TMC_ADDR_LOW, 8'h00);
         wr(TMC_ADDR_CONTROL, {2'b00, p[1:0], 4'h1});
         repeat (256) @(posedge clk);
         wr(TMC_ADDR_CONTROL, 8'h00);
         rng((64 >> p) - 1, (64 >> p) + 2);
      end
      e = got;
      repeat (40) @(posedge clk);
      rd(TMC_ADDR_LOW);
      chk(got, e);
      wr(TMC_ADDR_CONTROL, 8'h80);
      wr(TMC_ADDR_HIGH, 8'h12);
      wr(TMC_ADDR_LOW, 8'h34);
      wr(TMC_ADDR_CONTROL, 8'h00);
      rd(TMC_ADDR_HIGH);
      chk(got, 32'h12);
      wr(TMC_ADDR_HIGH, 8'h77);
      wr(TMC_ADDR_CONTROL, 8'h80);
      rd(TMC_ADDR_HIGH);
      chk(got, 32'h12);
      rd(TMC_ADDR_LOW);
      rd(TMC_ADDR_HIGH);
      chk(got, 32'h77);
      wr(TMC_ADDR_HIGH, 8'hff);
      wr(TMC_ADDR_LOW, 8'hfc);
      wr(TMC_ADDR_STATUS, 8'h03);
      wr(TMC_ADDR_CONTROL, 8'h01);
      for (int k = 0; ovf !== 1'b1 && k < 200; k++) @(posedge clk);
      chk({30'h0, ovf, irq}, 32'h3);
      wr(TMC_ADDR_CONTROL, 8'h00);
      rng(0, 2);
      wr(TMC_ADDR_STATUS, 8'h03);
      rd(TMC_ADDR_STATUS);
      chk(got, 32'h2);
      for (int i = 0; i < 2; i++) begin
         wr(TMC_ADDR_CONTROL, i ? 8'h06 : 8'h00);
         wr(TMC_ADDR_LOW, 8'h55);
         trig <= 1'b1;
         @(posedge clk);
         trig <= 1'b0;
         rd(TMC_ADDR_LOW);
         chk(got, i ? 32'h55 : 32'h0);
      end
      wr(TMC_ADDR_CONTROL, 8'h00);
      wr(TMC_ADDR_HIGH, 8'h33);
      // Trigger held across the low write; it may lose only at the write edge
      fork
         wr(TMC_ADDR_LOW, 8'h42);
         begin
            trig <= 1'b1;
            for (int k = 0; !(awv && awr) && k < 100; k++) @(posedge clk);
            @(posedge clk);
            trig <= 1'b0;
         end
      join
      rd(TMC_ADDR_LOW);
      chk(got, 32'h42);
      rd(TMC_ADDR_HIGH);
      chk(got, 32'h0);
      for (int m = 0; m < 3; m++) begin
         c = m == 0 ? 8'h03 : m == 1 ? 8'h07 : 8'h0b;
         wr(TMC_ADDR_CONTROL, c & 8'hfe);
         repeat (40) @(posedge clk);
         wr(TMC_ADDR_LOW, 8'h00);
         wr(TMC_ADDR_CONTROL, c);
         ext_run <= m < 2;
         repeat (160) @(posedge clk);
         ext_run <= 1'b0;
         wr(TMC_ADDR_CONTROL, c & 8'hfe);
         rng(14, 17);
      end
      sysclk <= 1'b1;
      repeat (2) @(posedge clk);
      rd(TMC_ADDR_CONTROL);
      chk(got, 32'h4a);
      chk({31'h0, osc_en}, 32'h1);
      // A second reset in mid-run must clear every control bit again
      sysclk <= 1'b0;
      rst <= 1'b1;
      repeat (5) @(posedge clk);
      chk({31'h0, osc_en}, 32'h0);
      rst <= 1'b0;
      rd(TMC_ADDR_CONTROL);
      chk(got, 32'h0);
      complete_run();
   end
endmodule : sixteen_bit_timer_counter_bench
